//--- core/cat_defs.svh
// Behaviour
// - Source 00: osc/12, or osc/6 double-speed
// - Source 01: osc/4, or osc/2 double-speed
// - Source 10 timer0 overflow, 11 external pin
// - One shared counter for all five modules
// - Idle gate bit stops counter during idle
// - Module 4 watchdog only while enabled
// - Overflow flag interrupts only when enabled
// - Run bit starts counter, clearing stops it
// - Overflow sets flag, may request interrupt
// - Overflow flag cleared only by software zero
// - Module match/capture sets sticky event flag
// - Six requests share one interrupt output
// - Capture, timer, output modes raise interrupts
// - Count and module pins shared with port
// - Modules configurable for capture, timer, output, PWM
// - Software may set overflow flag too
// - Module flag gated by own enable bit
`ifndef CAT_DEFS_SVH
`define CAT_DEFS_SVH

// ----------------------------------------
// Register word indexes, byte address = 4 x index
// ----------------------------------------
`define CAT_IDX_CTRL      8'hD8
`define CAT_IDX_MODE      8'hD9
`define CAT_IDX_CNT_LO    8'hE0
`define CAT_IDX_CNT_HI    8'hE1
`define CAT_IDX_MCFG0     8'hE2
`define CAT_IDX_MCFG4     8'hE6

// ----------------------------------------
// Field positions
// ----------------------------------------
`define CAT_CTRL_OVF_BIT  7
`define CAT_CTRL_RUN_BIT  6
`define CAT_MODE_IDLE_BIT 7
`define CAT_MODE_WD_BIT   6
`define CAT_MODE_IE_BIT   0
`define CAT_MCFG_IE_BIT   0

// ----------------------------------------
// Reset values and masks
// ----------------------------------------
`define CAT_CTRL_RST      8'h00
`define CAT_MODE_RST      8'h00
`define CAT_MCFG_RST      8'h00
`define CAT_CTRL_MASK     8'hDF
`define CAT_MODE_MASK     8'hC7
`define CAT_MCFG_MASK     8'h7F

// ----------------------------------------
// Oscillator division counts
// ----------------------------------------
`define CAT_DIV_12        4'hC
`define CAT_DIV_6         4'h6
`define CAT_DIV_4         4'h4
`define CAT_DIV_2         4'h2
`define CAT_NUM_MOD       5

`endif

//--- core/cat_pkg.sv
package cat_pkg;

   // ----------------------------------------
   // Count source selection
   // ----------------------------------------
   typedef enum logic [1:0] {
      CAT_SRC_OSC_SLOW = 2'h0,   // Oscillator / 12 (or / 6)
      CAT_SRC_OSC_FAST = 2'h1,   // Oscillator / 4 (or / 2)
      CAT_SRC_T0_OVF   = 2'h2,   // Timer 0 overflow
      CAT_SRC_EXT_PIN  = 2'h3    // External count input
   } cat_src_t;

   // Counter mode register layout
   typedef struct packed {
      logic       idle_gate;
      logic       module4_watchdog_enable;
      logic [2:0] rsvd;
      cat_src_t   count_source_select;
      logic       overflow_irq_enable;
   } cat_mode_t;

   // Counter control register layout
   typedef struct packed {
      logic       counter_overflow_flag;
      logic       counter_run;
      logic       rsvd;
      logic [4:0] module_event_flag;
   } cat_ctrl_t;

   // Per-module mode register layout
   typedef struct packed {
      logic rsvd;
      logic cmp_en;
      logic cap_rise;
      logic cap_fall;
      logic match_flag_en;
      logic toggle_en;
      logic pwm_en;
      logic module_irq_enable;
   } cat_mcfg_t;

endpackage

//--- core/cat_timebase.sv
`include "cat_defs.svh"

module cat_timebase (
   // Clock and reset
   input  wire logic                    clk_i,
   input  wire logic                    rst_i,
   // Wishbone classic slave
   input  wire logic                    cyc_i,
   input  wire logic                    stb_i,
   input  wire logic                    we_i,
   input  wire logic [9:0]              adr_i,
   input  wire logic [3:0]              sel_i,
   input  wire logic [31:0]             dat_i,
   output logic      [31:0]             dat_o,
   output logic                         ack_o,
   // System state
   input  wire logic                    double_speed_mode_i,
   input  wire logic                    cpu_idle_i,
   // Count event sources
   input  wire logic                    timer0_overflow_i,
   input  wire logic                    external_count_input_i,
   // Module side
   input  wire logic [4:0]              module_event_i,
   output logic      [15:0]             count_o,
   output logic                         count_tick_o,
   output cat_pkg::cat_mcfg_t [4:0]     module_cfg_o,
   output logic                         module4_watchdog_enable_o,
   // Port sharing
   output logic                         ext_pin_claim_o,
   output logic      [4:0]              module_pin_claim_o,
   // Shared interrupt request
   output logic                         irq_o
);

   // ----------------------------------------
   // Register state
   // ----------------------------------------
   // Software visible registers
   cat_pkg::cat_ctrl_t          ctrl_r;        // Run bit and flags
   cat_pkg::cat_ctrl_t          ctrl_nxt;      // Next control value
   cat_pkg::cat_mode_t          mode_r;        // Counter mode
   cat_pkg::cat_mcfg_t [4:0]    mcfg_r;        // Module modes

   // Time base and prescaler
   logic [15:0]                 cnt_r;         // Shared time base
   logic [15:0]                 cnt_nxt;       // Next counter value
   logic [3:0]                  div_r;         // Oscillator divider

   // Bus answer
   logic                        ack_r;         // Bus acknowledge
   logic [31:0]                 rdat_r;        // Captured read data

   // Registered outputs
   logic                        irq_r;         // Registered request
   logic                        tick_r;        // Registered tick copy
   logic                        ext_claim_r;   // Count pin in use
   logic [4:0]                  pin_claim_r;   // Module pins in use

   // ----------------------------------------
   // Synchronisers and edge detect
   // ----------------------------------------
   // External count pin
   logic                        ext_s1_r;      // External pin stage 1
   logic                        ext_s2_r;      // External pin stage 2
   logic                        ext_s3_r;      // Previous synced level

   // Timer 0 overflow line
   logic                        t0_s1_r;       // Timer 0 stage 1
   logic                        t0_s2_r;       // Timer 0 stage 2
   logic                        t0_s3_r;       // Previous synced level

   // ----------------------------------------
   // Bus decode
   // ----------------------------------------
   // Address and request
   wire  [7:0] word_idx   = adr_i[9:2];                       // Word index
   wire        bus_req    = cyc_i & stb_i;                    // Live request
   wire        wr_commit  = bus_req & we_i & ack_r & sel_i[0];// Write edge

   // Register hits
   wire        hit_ctrl   = (word_idx == `CAT_IDX_CTRL);
   wire        hit_mode   = (word_idx == `CAT_IDX_MODE);
   wire        hit_lo     = (word_idx == `CAT_IDX_CNT_LO);
   wire        hit_hi     = (word_idx == `CAT_IDX_CNT_HI);
   wire        hit_mcfg   = (word_idx >= `CAT_IDX_MCFG0) &&
                            (word_idx <= `CAT_IDX_MCFG4);
   wire  [2:0] mcfg_sel   = 3'(word_idx - `CAT_IDX_MCFG0);   // Module number
   wire  [7:0] wbyte      = dat_i[7:0];                       // Low lane data

   // Write strobes per register
   wire        wr_ctrl    = wr_commit & hit_ctrl;
   wire        wr_mode    = wr_commit & hit_mode;
   wire        wr_lo      = wr_commit & hit_lo;
   wire        wr_hi      = wr_commit & hit_hi;

   // ----------------------------------------
   // Read data selection, reserved bits zero
   // ----------------------------------------
   // Module mode read
   wire  [7:0] rd_mcfg    = hit_mcfg ? (mcfg_r[mcfg_sel] & `CAT_MCFG_MASK) : 8'h00;

   // Byte of the addressed register
   wire  [7:0] rd_byte    = hit_ctrl ? (ctrl_r & `CAT_CTRL_MASK) :
                            hit_mode ? (mode_r & `CAT_MODE_MASK) :
                            hit_lo   ? cnt_r[7:0] :
                            hit_hi   ? cnt_r[15:8] :
                            rd_mcfg;                          // Unmapped reads 0

   // ----------------------------------------
   // Count source selection
   // ----------------------------------------
   // Counter enable
   wire        run_gate   = ctrl_r.counter_run &
                            ~(mode_r.idle_gate & cpu_idle_i);

   // Prescaler length
   wire  [3:0] div_term   =
      (mode_r.count_source_select == cat_pkg::CAT_SRC_OSC_SLOW) ?
         (double_speed_mode_i ? `CAT_DIV_6 : `CAT_DIV_12) :
         (double_speed_mode_i ? `CAT_DIV_2 : `CAT_DIV_4);
   wire        div_hit    = (div_r >= 4'(div_term - 4'h1));   // Divider end

   // Edges of the synced inputs
   wire        ext_evt    = ext_s3_r & ~ext_s2_r;             // Falling edge
   wire        t0_evt     = t0_s2_r & ~t0_s3_r;               // Rising edge

   // Selected count event
   wire        src_evt    =
      (mode_r.count_source_select == cat_pkg::CAT_SRC_T0_OVF)  ? t0_evt  :
      (mode_r.count_source_select == cat_pkg::CAT_SRC_EXT_PIN) ? ext_evt :
      div_hit;

   // Advance and wrap
   wire        tick       = run_gate & src_evt;               // Counter advance
   wire        wrap       = tick & (cnt_r == 16'hFFFF);

   // ----------------------------------------
   // Interrupt combine
   // ----------------------------------------
   logic [4:0] mod_req;                                       // Gated module flags

   // Overflow request
   wire        ovf_req    = ctrl_r.counter_overflow_flag &
                            mode_r.overflow_irq_enable;

   // Shared request line
   wire        irq_nxt    = ovf_req | (|mod_req);

   // ----------------------------------------
   // Bus acknowledge and read capture
   // ----------------------------------------
   // One wait state, ack dropped in the cycle after it
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_r  <= 1'b0;
         rdat_r <= 32'h0000_0000;
      end else begin
         // Never two acks in a row
         ack_r  <= bus_req & ~ack_r;
         // Read byte taken with the request
         rdat_r <= {24'h00_0000, rd_byte};
      end
   end

   // ----------------------------------------
   // Input synchronisers
   // ----------------------------------------
   // Two flops per asynchronous source, third for edge detect
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         // Pin idles high, timer line low
         ext_s1_r <= 1'b1;
         ext_s2_r <= 1'b1;
         ext_s3_r <= 1'b1;
         t0_s1_r  <= 1'b0;
         t0_s2_r  <= 1'b0;
         t0_s3_r  <= 1'b0;
      end else begin
         // Two stages, then edge history
         ext_s1_r <= external_count_input_i;
         ext_s2_r <= ext_s1_r;
         ext_s3_r <= ext_s2_r;
         t0_s1_r  <= timer0_overflow_i;
         t0_s2_r  <= t0_s1_r;
         t0_s3_r  <= t0_s2_r;
      end
   end

   // ----------------------------------------
   // Oscillator prescaler
   // ----------------------------------------
   // Free running while the counter is enabled
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         div_r <= 4'h0;
      end else if (!run_gate || div_hit) begin
         // Restart while gated or at the end
         div_r <= 4'h0;
      end else begin
         // Count between ticks
         div_r <= div_r + 4'h1;
      end
   end

   // ----------------------------------------
   // Shared 16-bit time base
   // ----------------------------------------
   // Software byte writes override a tick
   always_comb begin
      cnt_nxt = cnt_r;
      if (tick) begin
         cnt_nxt = cnt_r + 16'h0001;
      end
      // Low byte write
      if (wr_lo) begin
         cnt_nxt[7:0] = wbyte;
      end
      // High byte write
      if (wr_hi) begin
         cnt_nxt[15:8] = wbyte;
      end
   end

   // Counter and tick copy
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cnt_r  <= 16'h0000;
         tick_r <= 1'b0;
      end else begin
         cnt_r  <= cnt_nxt;
         tick_r <= tick;
      end
   end

   // ----------------------------------------
   // Control register next value
   // ----------------------------------------
   // Hardware set wins over a software clear in the same cycle
   always_comb begin
      ctrl_nxt = ctrl_r;
      // Software write replaces every bit
      if (wr_ctrl) begin
         ctrl_nxt = cat_pkg::cat_ctrl_t'(wbyte & `CAT_CTRL_MASK);
      end
      // In hardware only the overflow sets it, and nothing in hardware clears it
      if (wrap) begin
         ctrl_nxt.counter_overflow_flag = 1'b1;
      end
      // Module events set sticky flags
      ctrl_nxt.module_event_flag = ctrl_nxt.module_event_flag |
                                   module_event_i;
      // Reserved bit reads zero
      ctrl_nxt.rsvd = 1'b0;
   end

   // ----------------------------------------
   // Control and mode registers
   // ----------------------------------------
   // Control every cycle, mode only on write
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_r <= cat_pkg::cat_ctrl_t'(`CAT_CTRL_RST);
         mode_r <= cat_pkg::cat_mode_t'(`CAT_MODE_RST);
      end else begin
         ctrl_r <= ctrl_nxt;
         if (wr_mode) begin
            mode_r <= cat_pkg::cat_mode_t'(wbyte & `CAT_MODE_MASK);
         end
      end
   end

   // ----------------------------------------
   // Per-module mode registers and requests
   // ----------------------------------------
   // Index over the five modules
   genvar m;
   generate
      for (m = 0; m < `CAT_NUM_MOD; m = m + 1) begin : g_mod
         // Write strobe for this module
         wire wr_m = wr_commit & hit_mcfg & (mcfg_sel == 3'(m));

         // Mode bits select capture, timer, output or PWM
         always_ff @(posedge clk_i) begin
            if (rst_i) begin
               // No function after reset
               mcfg_r[m] <= cat_pkg::cat_mcfg_t'(`CAT_MCFG_RST);
            end else if (wr_m) begin
               // Reserved bit kept zero
               mcfg_r[m] <= cat_pkg::cat_mcfg_t'(wbyte & `CAT_MCFG_MASK);
            end
         end

         // Flag reaches the shared line only with its own enable
         assign mod_req[m] = ctrl_r.module_event_flag[m] &
                             mcfg_r[m].module_irq_enable;

         // Module pin claimed while the module uses its pin
         always_ff @(posedge clk_i) begin
            if (rst_i) begin
               pin_claim_r[m] <= 1'b0;
            end else begin
               pin_claim_r[m] <= mcfg_r[m].cap_rise | mcfg_r[m].cap_fall |
                                 mcfg_r[m].toggle_en | mcfg_r[m].pwm_en;
            end
         end
      end
   endgenerate

   // ----------------------------------------
   // Interrupt and pin claim registers
   // ----------------------------------------
   // One cycle behind the flags and mode
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         // Quiet after reset
         irq_r       <= 1'b0;
         ext_claim_r <= 1'b0;
      end else begin
         irq_r       <= irq_nxt;
         ext_claim_r <= (mode_r.count_source_select ==
                         cat_pkg::CAT_SRC_EXT_PIN);
      end
   end

   // ----------------------------------------
   // Outputs, all from flops
   // ----------------------------------------
   // Bus side
   assign dat_o                     = rdat_r;
   assign ack_o                     = ack_r;

   // Time base
   assign count_o                   = cnt_r;
   assign count_tick_o              = tick_r;

   // Module side
   assign module_cfg_o              = mcfg_r;
   assign module4_watchdog_enable_o = mode_r.module4_watchdog_enable;

   // Port sharing and request
   assign ext_pin_claim_o           = ext_claim_r;
   assign module_pin_claim_o        = pin_claim_r;
   assign irq_o                     = irq_r;

endmodule

//--- tb/cat_timebase_asserts.sv
`include "cat_defs.svh"

module cat_timebase_asserts (
   // Clock and reset
   input wire logic                     clk_i,
   input wire logic                     rst_i,
   // Register bus
   input wire logic                     cyc_i,
   input wire logic                     stb_i,
   input wire logic                     we_i,
   input wire logic [9:0]               adr_i,
   input wire logic [3:0]               sel_i,
   input wire logic [31:0]              dat_i,
   input wire logic                     ack_o,
   // Counter and module side
   input wire logic [15:0]              count_o,
   input wire logic [4:0]               module_event_i,
   input wire cat_pkg::cat_mcfg_t [4:0] module_cfg_o,
   input wire logic                     module4_watchdog_enable_o,
   input wire logic                     ext_pin_claim_o,
   input wire logic                     irq_o
);
   timeunit 1ns;
   timeprecision 1ps;

   // ----------------------------------------
   // Decoded bus writes
   // ----------------------------------------
   wire       wr_w    = cyc_i & stb_i & we_i & ack_o & sel_i[0];   // Write taking effect
   wire [7:0] idx_w   = adr_i[9:2];                                // Word index
   wire       cnt_wr  = wr_w & (idx_w == `CAT_IDX_CNT_LO | idx_w == `CAT_IDX_CNT_HI);
   wire       mode_wr = wr_w & (idx_w == `CAT_IDX_MODE);           // Mode register write
   wire [4:0] en_w;                                                // Module irq enables
   logic      ovf_en_r;                                            // Mirror of overflow enable

   for (genvar g = 0; g < 5; g++) begin : g_en
      assign en_w[g] = module_cfg_o[g].module_irq_enable;
   end

   // Mirror follows mode writes, needed to know when overflow may interrupt
   always_ff @(posedge clk_i) begin
      if (rst_i) ovf_en_r <= 1'b0;
      else if (mode_wr) ovf_en_r <= dat_i[0];
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   // ----------------------------------------
   // Sequences and properties
   // ----------------------------------------
   sequence s_req;
      cyc_i && stb_i && !ack_o;
   endsequence
   sequence s_wrap;
      $past(count_o) == 16'hFFFF && count_o == 16'h0000 && !$past(cnt_wr);
   endsequence
   sequence s_mod_evt;
      (module_event_i & en_w) != 5'h00;
   endsequence

   property p_ack_pulse;
      s_req |=> ack_o ##1 !ack_o;
   endproperty
   property p_count_step;
      $changed(count_o) && !$past(cnt_wr) |-> count_o == $past(count_o) + 16'h0001;
   endproperty
   property p_ovf_irq;
      s_wrap ##0 ovf_en_r |=> irq_o;
   endproperty
   property p_mod_irq;
      s_mod_evt ##1 $stable(en_w) |=> irq_o;
   endproperty
   property p_irq_hold;
      !wr_w ##1 irq_o |=> irq_o;
   endproperty
   property p_wd_write;
      mode_wr |=> module4_watchdog_enable_o == $past(dat_i[6]);
   endproperty
   property p_wd_hold;
      !mode_wr |=> $stable(module4_watchdog_enable_o);
   endproperty
   property p_ext_claim;
      mode_wr |-> ##2 ext_pin_claim_o == ($past(dat_i[2:1], 2) == 2'h3);
   endproperty

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   a_ack_pulse: assert property (p_ack_pulse)
      else $error("bus ack not a single pulse one cycle after request");
   a_count_step: assert property (p_count_step)
      else $error("counter moved by other than one step");
   a_ovf_irq: assert property (p_ovf_irq)
      else $error("wrap with overflow enable gave no interrupt");
   a_mod_irq: assert property (p_mod_irq)
      else $error("enabled module event gave no interrupt");
   a_irq_hold: assert property (p_irq_hold)
      else $error("interrupt dropped without a register write");
   a_wd_write: assert property (p_wd_write)
      else $error("watchdog enable does not follow mode write");
   a_wd_hold: assert property (p_wd_hold)
      else $error("watchdog enable changed without mode write");
   a_ext_claim: assert property (p_ext_claim)
      else $error("count pin claim does not follow source select");
endmodule

bind cat_timebase cat_timebase_asserts u_asserts (.*);

//--- tb/test_cat_timebase.sv
`include "cat_defs.svh"

module test_cat_timebase;
   timeunit 1ns;
   timeprecision 1ps;

   // ----------------------------------------
   // Design signals
   // ----------------------------------------
   logic                     clk_i = 1'b0;                  // System clock
   logic                     rst_i = 1'b1;                  // Synchronous reset
   logic                     cyc_i = 1'b0;                  // Bus cycle
   logic                     stb_i = 1'b0;                  // Bus strobe
   logic                     we_i = 1'b0;                   // Bus direction
   logic [9:0]               adr_i = 10'h000;               // Byte address
   logic [3:0]               sel_i = 4'hF;                  // Byte enables
   logic [31:0]              dat_i = 32'h0000_0000;         // Write data
   logic                     double_speed_mode_i = 1'b0;    // Double speed
   logic                     cpu_idle_i = 1'b1;             // Idle state
   logic                     timer0_overflow_i = 1'b0;      // Timer 0 events
   logic                     external_count_input_i = 1'b1; // Count pin, idles high
   logic [4:0]               module_event_i = 5'h00;        // Module events
   logic [31:0]              dat_o;
   logic                     ack_o;
   logic [15:0]              count_o;
   logic                     count_tick_o;
   cat_pkg::cat_mcfg_t [4:0] module_cfg_o;
   logic                     module4_watchdog_enable_o;
   logic                     ext_pin_claim_o;
   logic [4:0]               module_pin_claim_o;
   logic                     irq_o;
   // Bench state
   int                       seed = 76393;                  // Fixed seed
   int                       failures = 0;                  // Mismatches
   int                       cmp_count = 0;                 // Comparisons
   int                       k;                             // Event count
   logic [4:0]               ev;                            // Event pattern
   logic [4:0]               en;                            // Expected irq enables
   logic [4:0]               cl;                            // Expected pin claims
   logic [7:0]               cfg [5];                       // Module settings
   int                       ticks;                         // Advances seen
   int                       tick_base;                     // Advances before a run

   cat_timebase dut (.*);

   always #5 clk_i = ~clk_i;

   // Counter advances seen on the tick output
   always @(posedge clk_i) if (count_tick_o === 1'b1) ticks <= ticks + 1;

   // ----------------------------------------
   // Checking and bus tasks
   // ----------------------------------------
   task automatic chk(input logic [15:0] e, input logic [15:0] g);
      cmp_count++;
      if (g !== e) begin
         failures++;
         $display("Error %0t exp %h got %h", $time, e, g);
      end
   endtask

   task automatic chk_b(input logic e, input logic g);
      chk({15'h0000, e}, {15'h0000, g});
   endtask

   // One classic cycle, held until ack is seen
   task automatic wb(input logic w, input logic [7:0] idx, input logic [7:0] d,
                     output logic [7:0] q);
      int n;
      n = 0;
      @(posedge clk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      adr_i <= {idx, 2'b00};
      dat_i <= {24'h00_0000, d};
      do begin
         @(posedge clk_i);
         n++;
      end while (ack_o !== 1'b1 && n < 50);
      q = dat_o[7:0];
      if (n >= 50) failures++;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      we_i <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      logic [7:0] q;
      wb(1'b1, idx, d, q);
   endtask

   task automatic rd(input logic [7:0] idx, input logic [7:0] e);
      logic [7:0] q;
      wb(1'b0, idx, 8'h00, q);
      chk({8'h00, e}, {8'h00, q});
   endtask

   task automatic rd_cnt(input logic [15:0] e);
      logic [7:0] lo;
      logic [7:0] hi;
      wb(1'b0, `CAT_IDX_CNT_LO, 8'h00, lo);
      wb(1'b0, `CAT_IDX_CNT_HI, 8'h00, hi);
      chk(e, {hi, lo});
      chk(e, count_o);
      chk(e, 16'(ticks - tick_base));
   endtask

   // Ticks in a run span of 121 cycles, or none while gated in idle
   function automatic logic [15:0] rate_exp(input logic src, input logic ds, input logic gt);
      int nd;
      nd = src ? (ds ? 2 : 4) : (ds ? 6 : 12);
      return gt ? 16'h0000 : 16'(121 / nd);
   endfunction

   task automatic final_report();
      $display("Comparisons %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask

   // Watchdog against a hung handshake
   initial begin
      repeat (10000) @(posedge clk_i);
      failures++;
      final_report();
   end

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      rd(`CAT_IDX_CTRL, 8'h00);
      rd(`CAT_IDX_MODE, 8'h00);
      rd(8'h10, 8'h00);
      wr(`CAT_IDX_MODE, 8'hC6);
      rd(`CAT_IDX_MODE, 8'hC6);
      chk_b(1'b1, module4_watchdog_enable_o);
      chk_b(1'b1, ext_pin_claim_o);
      // Internal rates, double speed and idle gating
      for (int i = 0; i < 8; i++) begin
         double_speed_mode_i <= i[1];
         wr(`CAT_IDX_MODE, {i[2], 5'h00, i[0], 1'b0});
         wr(`CAT_IDX_CNT_LO, 8'h00);
         wr(`CAT_IDX_CNT_HI, 8'h00);
         tick_base = ticks;
         wr(`CAT_IDX_CTRL, 8'h40);
         repeat (118) @(posedge clk_i);
         wr(`CAT_IDX_CTRL, 8'h00);
         rd_cnt(rate_exp(i[0], i[1], i[2]));
      end
      // Wrap, overflow flag and its interrupt gating
      cpu_idle_i <= 1'b0;
      wr(`CAT_IDX_MODE, 8'h03);
      wr(`CAT_IDX_CNT_LO, 8'hFE);
      wr(`CAT_IDX_CNT_HI, 8'hFF);
      wr(`CAT_IDX_CTRL, 8'h40);
      repeat (6) @(posedge clk_i);
      rd(`CAT_IDX_CTRL, 8'hC0);
      chk_b(1'b1, irq_o);
      wr(`CAT_IDX_MODE, 8'h02);
      rd(`CAT_IDX_CTRL, 8'hC0);
      chk_b(1'b0, irq_o);
      wr(`CAT_IDX_MODE, 8'h03);
      rd(`CAT_IDX_MODE, 8'h03);
      chk_b(1'b1, irq_o);
      wr(`CAT_IDX_CTRL, 8'h00);
      rd(`CAT_IDX_CTRL, 8'h00);
      chk_b(1'b0, irq_o);
      wr(`CAT_IDX_CTRL, 8'h80);
      rd(`CAT_IDX_CTRL, 8'h80);
      chk_b(1'b1, irq_o);
      wr(`CAT_IDX_CTRL, 8'h00);
      // Timer 0 and pin events, both toggling, only the selected one counts
      for (int s = 2; s < 4; s++) begin
         wr(`CAT_IDX_MODE, {5'h00, s[1:0], 1'b0});
         wr(`CAT_IDX_CNT_LO, 8'h00);
         chk_b(s == 3, ext_pin_claim_o);
         wr(`CAT_IDX_CNT_HI, 8'h00);
         tick_base = ticks;
         wr(`CAT_IDX_CTRL, 8'h40);
         k = 3 + ($random(seed) & 3);
         repeat (k) begin
            @(posedge clk_i);
            timer0_overflow_i <= 1'b1;
            external_count_input_i <= 1'b0;
            repeat (3) @(posedge clk_i);
            timer0_overflow_i <= 1'b0;
            external_count_input_i <= 1'b1;
            repeat (2) @(posedge clk_i);
         end
         repeat (6) @(posedge clk_i);
         wr(`CAT_IDX_CTRL, 8'h00);
         rd_cnt(16'(k));
      end
      // Module flags, enables and pin claims, all five at once first
      for (int it = 0; it < 6; it++) begin
         ev = (it == 0) ? 5'h1F : 5'($random(seed));
         for (int n = 0; n < 5; n++) begin
            cfg[n] = 8'($random(seed)) & 8'h7F;
            en[n] = cfg[n][0];
            cl[n] = cfg[n][5] | cfg[n][4] | cfg[n][2] | cfg[n][1];
            wr(8'hE2 + 8'(n), cfg[n]);
         end
         @(posedge clk_i);
         module_event_i <= ev;
         @(posedge clk_i);
         module_event_i <= 5'h00;
         repeat (2) @(negedge clk_i);
         chk_b(|(ev & en), irq_o);
         chk({11'h000, cl}, {11'h000, module_pin_claim_o});
         for (int n = 0; n < 5; n++) chk({8'h00, cfg[n]}, {8'h00, module_cfg_o[n]});
         rd(`CAT_IDX_CTRL, {3'b000, ev});
         wr(`CAT_IDX_CTRL, 8'h00);
         rd(`CAT_IDX_CTRL, 8'h00);
      end
      final_report();
   end
endmodule
